// >>> src/csda_core.sv
// Operation
// RULE1: Compare addressed byte with accumulator, unsigned; neither is changed.
// RULE2: Byte below accumulator discards fetched word, runs a nop; two cycles.
// RULE3: Skipped two-word instruction makes three cycles, extra ones all idle.
// RULE4: Bank bit 0 addresses the fixed direct-access bank.
// RULE5: Bank bit 1 forms address from bank select register and operand.
// RULE6: Low nibble above 9 or nibble carry set: add 6 to low nibble.
// RULE7: High nibble plus nibble carry above 9 or carry: add 6 as well.
// RULE8: Decimal adjust corrects 8-bit packed BCD sum in accumulator.
// RULE9: Compare is 0110 000a plus file byte; adjust is word 0x0007.
// RULE10: Compare keeps flags; adjust writes carry and accumulator in Q4.
`timescale 1ns/1ps
module csda_core
	import csda_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] instr_word,
	input  wire logic        next_two_word,
	input  wire logic [3:0]  bank_select_register_wdata,
	input  wire logic        bank_select_register_we,
	input  wire logic [7:0]  acc_load_val,
	input  wire logic        acc_load,
	input  wire logic        carry_in,
	input  wire logic        nibble_carry_in,
	input  wire logic [7:0]  mem_rdata,
	output logic      [11:0] mem_addr,
	output logic             mem_rd,
	output logic      [7:0]  acc,
	output logic             carry_out,
	output logic             carry_we,
	output logic             discard_fetch,
	output logic             instr_done,
	output logic      [1:0]  phase
);
	import csda_pkg::*;

	// One clock domain, so every check shares this clock and reset
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic [1:0]  phase_q, phase_d;
	csda_state_e st_q, st_d;
	logic [7:0]  acc_q, acc_d;
	logic [3:0]  bank_select_register_q, bank_select_register_d;
	logic [11:0] addr_q, addr_d;
	logic        rd_q, rd_d, cy_q, cy_d, cwe_q, cwe_d;
	logic        disc_q, disc_d, done_q, done_d, two_q, two_d;
	logic        is_cmp, is_adjust, less;
	logic [3:0]  lo_n, hi_n;
	logic [4:0]  hi_sum, hi_res;
	logic        lo_fix;

	assign is_cmp = instr_word[15:9] == CSDA_CMP_OPC;    // [RULE9]
	assign is_adjust = instr_word == CSDA_ADJUST_WORD;   // [RULE9]
	assign less   = mem_rdata < acc_q;                   // [RULE1] [RULE2]
	assign lo_fix = (acc_q[3:0] > CSDA_NIB_MAX) || nibble_carry_in; // [RULE6]
	assign lo_n   = lo_fix ? acc_q[3:0] + CSDA_NIB_ADJ : acc_q[3:0];
	assign hi_sum = {1'b0, acc_q[7:4]} + {4'h0, nibble_carry_in};
	// [RULE7]
	assign hi_res = (hi_sum > {1'b0, CSDA_NIB_MAX}) || carry_in ?
		hi_sum + {1'b0, CSDA_NIB_ADJ} : hi_sum;
	assign hi_n   = hi_res[3:0];

	always_comb begin
		phase_d = phase_q + 2'h1;
		st_d    = st_q;
		acc_d   = acc_q;
		bank_select_register_d = bank_select_register_we ?
			bank_select_register_wdata : bank_select_register_q;
		addr_d  = addr_q;
		rd_d    = 1'b0;
		cy_d    = cy_q;
		cwe_d   = 1'b0;
		disc_d  = disc_q;
		done_d  = 1'b0;
		two_d   = two_q;
		case (st_q)
			CSDA_EXEC: begin
				if (phase_q == CSDA_Q1 && is_cmp) begin
					// Address ready for the Q2 read
					if (instr_word[8])
						addr_d = {bank_select_register_q,
							instr_word[7:0]};         // [RULE5]
					else
						addr_d = {CSDA_ACC_BANK, instr_word[7:0]}; // [RULE4]
					rd_d = 1'b1;
				end
				if (phase_q == CSDA_Q3 && is_cmp && less) begin
					// Fetched word dropped; flags untouched [RULE10]
					disc_d = 1'b1;                         // [RULE2]
					two_d  = next_two_word;                // [RULE3]
				end
				if (phase_q == CSDA_Q3 && is_adjust) begin
					acc_d = {hi_n, lo_n};                  // [RULE8] [RULE10]
					cy_d  = hi_res[4] | carry_in;
					cwe_d = 1'b1;
				end
				if (phase_q == CSDA_Q4) begin
					if (disc_q)
						st_d = CSDA_NOP1;
					else
						done_d = 1'b1;
				end
			end
			CSDA_NOP1: begin
				if (phase_q == CSDA_Q4) begin
					if (two_q) begin
						st_d = CSDA_NOP2;                  // [RULE3]
					end else begin
						st_d   = CSDA_EXEC;
						disc_d = 1'b0;
						done_d = 1'b1;
					end
				end
			end
			CSDA_NOP2: begin
				if (phase_q == CSDA_Q4) begin
					st_d   = CSDA_EXEC;
					disc_d = 1'b0;
					two_d  = 1'b0;
					done_d = 1'b1;
				end
			end
			default: st_d = CSDA_EXEC;
		endcase
		// Host load only between instructions so it never races the adjust
		if (acc_load && phase_q == CSDA_Q4 && st_q == CSDA_EXEC && !cwe_q)
			acc_d = acc_load_val;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_q <= CSDA_Q1;
			st_q    <= CSDA_EXEC;
			acc_q   <= CSDA_ACC_RST;
			bank_select_register_q <= CSDA_BANK_SEL_RST;
			addr_q  <= 12'h000;
			rd_q    <= 1'b0;
			cy_q    <= 1'b0;
			cwe_q   <= 1'b0;
			disc_q  <= 1'b0;
			done_q  <= 1'b0;
			two_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			st_q    <= st_d;
			acc_q   <= acc_d;
			bank_select_register_q <= bank_select_register_d;
			addr_q  <= addr_d;
			rd_q    <= rd_d;
			cy_q    <= cy_d;
			cwe_q   <= cwe_d;
			disc_q  <= disc_d;
			done_q  <= done_d;
			two_q   <= two_d;
		end
	end

	assign mem_addr      = addr_q;
	assign mem_rd        = rd_q;
	assign acc           = acc_q;
	assign carry_out     = cy_q;
	assign carry_we      = cwe_q;
	assign discard_fetch = disc_q;
	assign instr_done    = done_q;
	assign phase         = phase_q;

	// Assertions
	cmp_keeps_acc_a: assert property ( // [RULE1]
		is_cmp && st_q == CSDA_EXEC && !acc_load |=> $stable(acc_q))
		else $error("compare changed accumulator");
	mem_rd_pulse_a: assert property ( // [RULE1]
		mem_rd |=> !mem_rd)
		else $error("read strobe longer than one clock");
	skip_discard_a: assert property ( // [RULE2]
		st_q == CSDA_EXEC && phase_q == CSDA_Q3 && is_cmp && less
		|=> disc_q && st_q == CSDA_EXEC ##1 st_q == CSDA_NOP1)
		else $error("skip did not discard");
	no_skip_a: assert property ( // [RULE1]
		st_q == CSDA_EXEC && phase_q == CSDA_Q3 && is_cmp && !less
		|=> !disc_q ##1 instr_done)
		else $error("compare skipped without cause");
	skip_one_word_a: assert property ( // [RULE2]
		st_q == CSDA_NOP1 && !two_q && phase_q == CSDA_Q4
		|=> st_q == CSDA_EXEC && instr_done && !disc_q)
		else $error("one-word skip length wrong");
	skip_two_word_a: assert property ( // [RULE3]
		st_q == CSDA_NOP1 && two_q && phase_q == CSDA_Q4
		|=> st_q == CSDA_NOP2 ##4 st_q == CSDA_EXEC)
		else $error("two-word skip length wrong");
	access_bank_a: assert property ( // [RULE4]
		st_q == CSDA_EXEC && phase_q == CSDA_Q1 && is_cmp && !instr_word[8]
		|=> mem_rd && addr_q[11:8] == CSDA_ACC_BANK)
		else $error("access bank address wrong");
	bank_sel_a: assert property ( // [RULE5]
		st_q == CSDA_EXEC && phase_q == CSDA_Q1 && is_cmp && instr_word[8]
		|=> addr_q[11:8] == $past(bank_select_register_q))
		else $error("bank select address wrong");
	adj_low_a: assert property ( // [RULE6]
		st_q == CSDA_EXEC && phase_q == CSDA_Q3 && is_adjust
		&& !nibble_carry_in && acc_q[3:0] <= CSDA_NIB_MAX
		|=> acc_q[3:0] == $past(acc_q[3:0]))
		else $error("low nibble changed");
	adj_low_fix_a: assert property ( // [RULE6]
		st_q == CSDA_EXEC && phase_q == CSDA_Q3 && is_adjust
		&& (acc_q[3:0] > CSDA_NIB_MAX || nibble_carry_in)
		|=> acc_q[3:0] == $past(acc_q[3:0]) + CSDA_NIB_ADJ)
		else $error("low nibble not adjusted");
	adj_high_a: assert property ( // [RULE7]
		st_q == CSDA_EXEC && phase_q == CSDA_Q3 && is_adjust && carry_in
		|=> acc_q[7:4] == $past(acc_q[7:4]) + CSDA_NIB_ADJ
		+ {3'h0, $past(nibble_carry_in)} && carry_out)
		else $error("high nibble adjust wrong");
	adj_q4_write_a: assert property ( // [RULE8] [RULE10]
		carry_we |-> phase_q == CSDA_Q4 && !disc_q)
		else $error("adjust write not in Q4");
	cmp_no_flags_a: assert property ( // [RULE10]
		st_q != CSDA_EXEC |-> !carry_we)
		else $error("flags written during skip");
	cmp_flag_free_a: assert property ( // [RULE10]
		st_q == CSDA_EXEC && is_cmp |=> !carry_we)
		else $error("compare wrote a flag");
	decode_a: assert property ( // [RULE9]
		st_q == CSDA_EXEC && phase_q == CSDA_Q1 && !is_cmp |=> !mem_rd)
		else $error("read without compare");
	cover_skip_c: cover property (st_q == CSDA_NOP1);
	cover_skip2_c: cover property (st_q == CSDA_NOP2);
	cover_adj_c: cover property (carry_we && carry_out);
	cover_no_skip_c: cover property (
		st_q == CSDA_EXEC && phase_q == CSDA_Q4 && is_cmp && !disc_q);
endmodule : csda_core

// >>> include/csda_pkg.sv
package csda_pkg;
	// Instruction encodings
	localparam logic [6:0]  CSDA_CMP_OPC  = 7'h30;   // 0110 000, then a, f
	localparam logic [15:0] CSDA_ADJUST_WORD = 16'h0007;
	localparam logic [3:0]  CSDA_NIB_MAX  = 4'h9;
	localparam logic [3:0]  CSDA_NIB_ADJ  = 4'h6;
	localparam logic [3:0]  CSDA_ACC_BANK = 4'h0;    // Fixed direct bank
	localparam logic [7:0]  CSDA_ACC_RST  = 8'h00;
	localparam logic [3:0]  CSDA_BANK_SEL_RST = 4'h0;
	localparam logic [1:0]  CSDA_Q1       = 2'h0;
	localparam logic [1:0]  CSDA_Q2       = 2'h1;
	localparam logic [1:0]  CSDA_Q3       = 2'h2;
	localparam logic [1:0]  CSDA_Q4       = 2'h3;
	localparam int          CSDA_SKIP1    = 1;
	localparam int          CSDA_SKIP2    = 2;
	typedef enum logic [1:0] {
		CSDA_EXEC  = 2'b00,
		CSDA_NOP1  = 2'b01,
		CSDA_NOP2  = 2'b10
	} csda_state_e;
endpackage : csda_pkg

// >>> tb/csda_mem_model.sv
`timescale 1ns/1ps
module csda_mem_model (
	input  wire logic        core_clk,
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_rd,
	output logic      [7:0]  mem_rdata
);
	// Contents follow the address, so the bench can predict every byte
	always_ff @(posedge core_clk) begin
		if (mem_rd) begin
			mem_rdata <= mem_addr[7:0] ^ {2{mem_addr[11:8]}};
		end else begin
			// Stale data flips so a late sample cannot match by luck
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : csda_mem_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import csda_pkg::*;
	logic        core_clk = 0, rst_n = 0, next_two_word = 0;
	logic        bank_select_register_we = 0;
	logic        acc_load = 0, carry_in = 0, nibble_carry_in = 0;
	logic [15:0] instr_word = 16'h0000;
	logic [3:0]  bank_select_register_wdata = 4'h0;
	logic [7:0]  acc_load_val = 8'h00, mem_rdata, acc;
	logic [11:0] mem_addr;
	logic [1:0]  phase;
	logic        mem_rd, carry_out, carry_we, discard_fetch, instr_done;
	int          miscompares = 0, comparisons = 0;
	always #25 core_clk = ~core_clk;
	csda_core csda_core_i (.core_clk, .rst_n, .instr_word, .next_two_word,
		.bank_select_register_wdata, .bank_select_register_we, .acc_load_val,
		.acc_load, .carry_in, .nibble_carry_in, .mem_rdata, .mem_addr, .mem_rd,
		.acc, .carry_out, .carry_we, .discard_fetch, .instr_done, .phase);
	csda_mem_model csda_mem_model_i (.core_clk, .mem_addr, .mem_rd, .mem_rdata);
	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	task close_out;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Accumulator load only lands in Q4, so the instruction goes in alongside it
	task go(input logic [15:0] iw, input logic [7:0] av);
		int n;
		for (n = 0; n < 8 && phase !== CSDA_Q4; n++) tick;
		if (phase !== CSDA_Q4) begin
			miscompares++;
			close_out;
		end
		acc_load = 1;
		acc_load_val = av;
		instr_word = iw;
		tick;
		acc_load = 0;
	endtask : go
	task cmp(input logic a, input logic [7:0] f, av, input logic two);
		logic [11:0] ad;
		logic [7:0]  d;
		int          i, dis;
		ad = {a ? bank_select_register_wdata : CSDA_ACC_BANK, f};
		d = ad[7:0] ^ {2{ad[11:8]}};
		next_two_word = two;
		go({CSDA_CMP_OPC, a, f}, av);
		dis = 0;
		// The idle cycle before this one also ends with a done pulse
		for (i = 0; i < 16 && (i == 0 || instr_done !== 1'b1); i++) begin
			if (i == 1) `CHK(mem_addr, ad)
			if (i == 1) `CHK(mem_rd, 1'b1)
			`CHK(carry_we, 1'b0)
			dis += (discard_fetch === 1'b1);
			tick;
		end
		if (instr_done !== 1'b1) begin
			miscompares++;
			close_out;
		end
		// A neutral word keeps the next Q1 from decoding this one again
		instr_word = 16'h0000;
		`CHK(i, d < av ? (two ? 12 : 8) : 4)
		`CHK(dis, d < av ? (two ? 9 : 5) : 0)
		`CHK(acc, av)
	endtask : cmp
	task adjust(input logic [7:0] av, input logic c, nc);
		logic [3:0] lo;
		logic [4:0] hs;
		int         i;
		lo = av[3:0];
		if (lo > CSDA_NIB_MAX || nc) lo = lo + CSDA_NIB_ADJ;
		hs = av[7:4] + nc;
		if (hs > CSDA_NIB_MAX || c) hs = hs + CSDA_NIB_ADJ;
		carry_in = c;
		nibble_carry_in = nc;
		go(CSDA_ADJUST_WORD, av);
		for (i = 0; i < 8 && (i == 0 || instr_done !== 1'b1); i++) begin
			if (i == 2) `CHK(acc, av)
			if (i == 3) `CHK({carry_we, carry_out, acc},
				{1'b1, hs[4] | c, hs[3:0], lo})
			tick;
		end
		if (instr_done !== 1'b1) begin
			miscompares++;
			close_out;
		end
		instr_word = 16'h0000;
		`CHK(i, 4)
	endtask : adjust
	task reset_check;
		rst_n = 0;
		tick;
		tick;
		rst_n = 1;
		// Bank select register is cleared along with the rest of the core
		bank_select_register_wdata = CSDA_BANK_SEL_RST;
		`CHK({acc, phase}, {CSDA_ACC_RST, CSDA_Q1})
		`CHK({discard_fetch, instr_done, carry_we, mem_rd}, 4'h0)
		tick;
		`CHK(phase, CSDA_Q2)
	endtask : reset_check
	initial begin
		repeat (4) @(posedge core_clk);
		#1 rst_n = 1;
		cmp(1'b0, 8'h40, 8'h41, 1'b0);
		cmp(1'b0, 8'h40, 8'h40, 1'b1);
		cmp(1'b0, 8'hff, 8'h00, 1'b1);
		bank_select_register_wdata = 4'h5;
		bank_select_register_we = 1;
		tick;
		bank_select_register_we = 0;
		cmp(1'b1, 8'h12, 8'h48, 1'b1);
		cmp(1'b1, 8'h12, 8'h48, 1'b0);
		cmp(1'b1, 8'h12, 8'h47, 1'b0);
		adjust(8'ha5, 1'b0, 1'b0);
		adjust(8'h99, 1'b0, 1'b1);
		adjust(8'h34, 1'b1, 1'b0);
		adjust(8'h0b, 1'b0, 1'b0);
		reset_check;
		cmp(1'b1, 8'h12, 8'h13, 1'b0);
		close_out;
	end
endmodule : tb_top
